// >>> rtl/mlt_pkg.sv
// Purpose: Shared constants and types for the layer-2 address table.
// Assumes: 100 MHz core clock, 32-bit APB register access.
// Notes: Register offsets are byte addresses of aligned words.
package mlt_pkg;

  localparam int ADDR_W = 48;
  localparam int VLAN_W = 12;
  localparam int PORT_W = 4;
  localparam int MASK_W = 16;
  localparam int AGE_W = 10;
  localparam int APB_AW = 8;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEC_NS = 1_000_000_000;
  localparam int CYCLES_PER_SEC = SEC_NS / CLK_PERIOD_NS;

  // Aging period in seconds
  localparam logic [AGE_W-1:0] AGE_DEF = 10'h12C;
  localparam logic [AGE_W-1:0] AGE_MIN = 10'h00A;
  localparam logic [AGE_W-1:0] AGE_MAX = 10'h276;

  // Usable VLAN range
  localparam logic [VLAN_W-1:0] VLAN_MIN = 12'h001;
  localparam logic [VLAN_W-1:0] VLAN_MAX = 12'hFFE;

  localparam logic [PORT_W-1:0] FIRST_GIGABIT_PORT = 4'h0;

  // Register offsets
  localparam logic [APB_AW-1:0] REG_KEY_LO = 8'h00;
  localparam logic [APB_AW-1:0] REG_KEY_HI = 8'h04;
  localparam logic [APB_AW-1:0] REG_KEY_SEL = 8'h08;
  localparam logic [APB_AW-1:0] REG_CMD = 8'h0C;
  localparam logic [APB_AW-1:0] REG_STATUS = 8'h10;
  localparam logic [APB_AW-1:0] REG_AGE = 8'h14;
  localparam logic [APB_AW-1:0] REG_RES_LO = 8'h18;
  localparam logic [APB_AW-1:0] REG_RES_HI = 8'h1C;
  localparam logic [APB_AW-1:0] REG_RES_INFO = 8'h20;

  // Field positions
  localparam int KEY_PORT_LSB = 16;
  localparam int CMD_DYN_ONLY_BIT = 4;
  localparam int CMD_PORT_FLT_BIT = 5;
  localparam int STAT_FOUND_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_FULL_BIT = 2;
  localparam int INFO_KIND_LSB = 12;
  localparam int INFO_MASK_LSB = 16;

  typedef enum logic [1:0] {
    KIND_DYN = 2'h0,
    KIND_STATIC = 2'h1,
    KIND_FILTER = 2'h2
  } mlt_kind_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ADD_STATIC = 3'h1,
    OP_ADD_FILTER = 3'h2,
    OP_DELETE = 3'h3,
    OP_FLUSH = 3'h4,
    OP_PROMOTE = 3'h5,
    OP_NEXT = 3'h6
  } mlt_op_t;

  typedef struct packed {
    logic valid;
    mlt_kind_t kind;
    logic [VLAN_W-1:0] vlan;
    logic [ADDR_W-1:0] addr;
    logic [PORT_W-1:0] port;
    logic [AGE_W-1:0] age;
  } mlt_entry_t;

  typedef struct packed {
    logic [ADDR_W-1:0] destination_hw_address;
    logic [ADDR_W-1:0] source_hw_address;
    logic [VLAN_W-1:0] vlan;
    logic [PORT_W-1:0] in_port;
  } mlt_frame_t;

  typedef struct packed {
    logic drop;
    logic hit;
    logic [MASK_W-1:0] mask;
  } mlt_fwd_t;

endpackage

// >>> rtl/mlt_sec_tick.sv
// Purpose: One-cycle pulse once per second for entry aging.
// Assumes: CYC_PER_SEC core clock cycles make one second.
// Notes: Free running from reset release.
`timescale 1ns/100ps
module mlt_sec_tick #(
  parameter int CYC_PER_SEC = mlt_pkg::CYCLES_PER_SEC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Tick
  output logic tick_o
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } mlt_tick_st_t;

  mlt_tick_st_t st;
  mlt_tick_st_t next_st;

  if (CYC_PER_SEC < 2) begin : g_chk
    $error("CYC_PER_SEC must be at least 2");
  end

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 32'(CYC_PER_SEC - 1)) begin
      next_st.cnt = 32'h0000_0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;

endmodule // mlt_sec_tick

// >>> rtl/mlt_match.sv
// Purpose: Exact match of one VLAN and address key against all entries.
// Assumes: Keys are unique in the table, so at most one entry hits.
// Notes: Lowest index wins should uniqueness ever be broken.
`timescale 1ns/100ps
module mlt_match #(
  parameter int DEPTH = 16,
  parameter int IW = 4
) (
  // Table contents
  input wire mlt_pkg::mlt_entry_t [DEPTH-1:0] tbl_i,
  // Key
  input wire logic [mlt_pkg::VLAN_W-1:0] vlan_i,
  input wire logic [mlt_pkg::ADDR_W-1:0] addr_i,
  // Result
  output logic hit_o,
  output logic [IW-1:0] idx_o
);

  if (DEPTH < 2 || (2 ** IW) < DEPTH) begin : g_chk
    $error("IW too narrow for DEPTH");
  end

  always_comb begin
    hit_o = 1'b0;
    idx_o = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (tbl_i[i].valid && tbl_i[i].vlan == vlan_i && tbl_i[i].addr == addr_i) begin
        hit_o = 1'b1;
        idx_o = IW'(i);
      end
    end
  end

endmodule // mlt_match

// >>> rtl/mlt_table.sv
// Purpose: Layer-2 address table with learning, aging, filters and management.
// Assumes: Frame requests and APB are synchronous to clk_sys_i.
// Notes: Port NUM_PORTS-1 is the CPU port; pready is always high.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
module mlt_table #(
  parameter int DEPTH = 16,
  parameter int NUM_PORTS = 10,
  parameter int CYC_PER_SEC = mlt_pkg::CYCLES_PER_SEC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [mlt_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Frame lookup request
  input wire logic frm_valid_i,
  input wire mlt_pkg::mlt_frame_t frm_i,
  input wire logic [mlt_pkg::MASK_W-1:0] frm_flood_mask_i,
  output logic frm_ready_o,
  // Forwarding decision
  output logic fwd_valid_o,
  output mlt_pkg::mlt_fwd_t fwd_o
);

  localparam int IW = $clog2(DEPTH);
  localparam logic [mlt_pkg::MASK_W-1:0] PORT_ALL = 16'((1 << NUM_PORTS) - 1);
  localparam int KEY_W = mlt_pkg::VLAN_W + mlt_pkg::ADDR_W;

  if (DEPTH < 2 || NUM_PORTS < 2 || NUM_PORTS > mlt_pkg::MASK_W) begin : g_chk
    $error("DEPTH or NUM_PORTS out of range");
  end

  typedef struct packed {
    logic [mlt_pkg::AGE_W-1:0] age_time;
    mlt_pkg::mlt_entry_t [DEPTH-1:0] tbl;
    logic [mlt_pkg::ADDR_W-1:0] key_addr;
    logic [mlt_pkg::VLAN_W-1:0] key_vlan;
    logic [mlt_pkg::PORT_W-1:0] key_port;
    logic cmd_pend;
    mlt_pkg::mlt_op_t cmd_op;
    logic cmd_dyn;
    logic cmd_pflt;
    logic found;
    logic err;
    mlt_pkg::mlt_entry_t res;
    logic fwd_valid;
    mlt_pkg::mlt_fwd_t fwd;
  } mlt_state_t;

  localparam int SW = $bits(mlt_state_t);
  localparam mlt_state_t ST_RST =
    mlt_state_t'({mlt_pkg::AGE_DEF, {(SW - mlt_pkg::AGE_W){1'b0}}});

  mlt_state_t st;
  mlt_state_t next_st;

  logic tick;
  logic dst_hit;
  logic [IW-1:0] dst_idx;
  logic src_hit;
  logic [IW-1:0] src_idx;
  logic key_hit;
  logic [IW-1:0] key_idx;
  logic free_hit;
  logic [IW-1:0] free_idx;
  logic nxt_hit;
  logic [IW-1:0] nxt_idx;
  logic [KEY_W-1:0] nxt_key;
  logic frm_take;
  logic apb_wr;
  logic addr_ok;

  function automatic logic [mlt_pkg::MASK_W-1:0] port_bit(input logic [mlt_pkg::PORT_W-1:0] p);
    port_bit = 16'h0001 << p;
  endfunction

  function automatic logic vlan_ok(input logic [mlt_pkg::VLAN_W-1:0] v);
    vlan_ok = (v >= mlt_pkg::VLAN_MIN) && (v <= mlt_pkg::VLAN_MAX);
  endfunction

  mlt_sec_tick #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .tick_o(tick)
  );

  mlt_match #(
    .DEPTH(DEPTH),
    .IW(IW)
  ) u_dst_match (
    .tbl_i(st.tbl),
    .vlan_i(frm_i.vlan),
    .addr_i(frm_i.destination_hw_address),
    .hit_o(dst_hit),
    .idx_o(dst_idx)
  );

  mlt_match #(
    .DEPTH(DEPTH),
    .IW(IW)
  ) u_src_match (
    .tbl_i(st.tbl),
    .vlan_i(frm_i.vlan),
    .addr_i(frm_i.source_hw_address),
    .hit_o(src_hit),
    .idx_o(src_idx)
  );

  mlt_match #(
    .DEPTH(DEPTH),
    .IW(IW)
  ) u_key_match (
    .tbl_i(st.tbl),
    .vlan_i(st.key_vlan),
    .addr_i(st.key_addr),
    .hit_o(key_hit),
    .idx_o(key_idx)
  );

  // Lowest free slot
  always_comb begin
    free_hit = 1'b0;
    free_idx = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (!st.tbl[i].valid) begin
        free_hit = 1'b1;
        free_idx = IW'(i);
      end
    end
  end

  // Smallest key strictly above the current key; filters never listed
  always_comb begin
    nxt_hit = 1'b0;
    nxt_idx = '0;
    nxt_key = '1;
    for (int i = 0; i < DEPTH; i++) begin
      if (st.tbl[i].valid && st.tbl[i].kind != mlt_pkg::KIND_FILTER
          && (!st.cmd_dyn || st.tbl[i].kind == mlt_pkg::KIND_DYN)
          && (!st.cmd_pflt || st.tbl[i].port == st.key_port)
          && {st.tbl[i].vlan, st.tbl[i].addr} > {st.key_vlan, st.key_addr}
          && (!nxt_hit || {st.tbl[i].vlan, st.tbl[i].addr} < nxt_key)) begin
        nxt_hit = 1'b1;
        nxt_idx = IW'(i);
        nxt_key = {st.tbl[i].vlan, st.tbl[i].addr};
      end
    end
  end

  // Frames stall for the one cycle a command runs, so table edits never collide
  assign frm_ready_o = !st.cmd_pend;
  assign frm_take = frm_valid_i && frm_ready_o;
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i <= mlt_pkg::REG_RES_INFO);

  always_comb begin
    next_st = st;
    next_st.fwd_valid = 1'b0;

    // Aging runs first so a refresh in the same cycle wins
    for (int i = 0; i < DEPTH; i++) begin
      if (tick && st.tbl[i].valid && st.tbl[i].kind == mlt_pkg::KIND_DYN) begin
        if ((st.tbl[i].age + 10'h001) >= st.age_time) begin
          next_st.tbl[i].valid = 1'b0;
        end else begin
          next_st.tbl[i].age = st.tbl[i].age + 10'h001;
        end
      end
    end

    if (frm_take) begin
      next_st.fwd_valid = 1'b1;
      next_st.fwd.drop = (dst_hit && st.tbl[dst_idx].kind == mlt_pkg::KIND_FILTER)
                      || (src_hit && st.tbl[src_idx].kind == mlt_pkg::KIND_FILTER);
      next_st.fwd.hit = dst_hit && st.tbl[dst_idx].kind != mlt_pkg::KIND_FILTER;
      if (next_st.fwd.drop) begin
        next_st.fwd.mask = '0;
      end else if (next_st.fwd.hit) begin
        next_st.fwd.mask = port_bit(st.tbl[dst_idx].port) & PORT_ALL
                         & ~port_bit(frm_i.in_port);
      end else begin
        next_st.fwd.mask = frm_flood_mask_i & PORT_ALL & ~port_bit(frm_i.in_port);
      end
      if (src_hit) begin
        if (st.tbl[src_idx].kind == mlt_pkg::KIND_DYN) begin
          next_st.tbl[src_idx].port = frm_i.in_port;
          next_st.tbl[src_idx].age = '0;
          next_st.tbl[src_idx].valid = 1'b1;
        end
        // Static and filter hits are left as they are
      end else if (free_hit) begin
        next_st.tbl[free_idx].valid = 1'b1;
        next_st.tbl[free_idx].kind = mlt_pkg::KIND_DYN;
        next_st.tbl[free_idx].vlan = frm_i.vlan;
        next_st.tbl[free_idx].addr = frm_i.source_hw_address;
        next_st.tbl[free_idx].port = frm_i.in_port;
        next_st.tbl[free_idx].age = '0;
      end
    end

    if (st.cmd_pend) begin
      next_st.cmd_pend = 1'b0;
      next_st.found = 1'b0;
      next_st.err = 1'b0;
      case (st.cmd_op)
        mlt_pkg::OP_ADD_STATIC, mlt_pkg::OP_ADD_FILTER: begin
          if (!vlan_ok(st.key_vlan) || (!key_hit && !free_hit)) begin
            next_st.err = 1'b1;
          end else if (st.cmd_op == mlt_pkg::OP_ADD_STATIC
                       && int'(st.key_port) >= NUM_PORTS) begin
            next_st.err = 1'b1;
          end else begin
            next_st.found = key_hit;
            next_st.tbl[key_hit ? key_idx : free_idx] = '{
              valid: 1'b1,
              kind: (st.cmd_op == mlt_pkg::OP_ADD_STATIC) ? mlt_pkg::KIND_STATIC
                                                          : mlt_pkg::KIND_FILTER,
              vlan: st.key_vlan,
              addr: st.key_addr,
              port: (st.cmd_op == mlt_pkg::OP_ADD_STATIC) ? st.key_port : '0,
              age: '0
            };
          end
        end
        mlt_pkg::OP_DELETE: begin
          if (key_hit && st.tbl[key_idx].kind != mlt_pkg::KIND_DYN) begin
            next_st.tbl[key_idx].valid = 1'b0;
            next_st.found = 1'b1;
          end else begin
            next_st.err = 1'b1;
          end
        end
        mlt_pkg::OP_FLUSH: begin
          for (int i = 0; i < DEPTH; i++) begin
            if (st.tbl[i].kind == mlt_pkg::KIND_DYN) begin
              next_st.tbl[i].valid = 1'b0;
            end
          end
        end
        mlt_pkg::OP_PROMOTE: begin
          if (key_hit && st.tbl[key_idx].kind == mlt_pkg::KIND_DYN) begin
            next_st.tbl[key_idx].kind = mlt_pkg::KIND_STATIC;
            next_st.tbl[key_idx].age = '0;
            next_st.tbl[key_idx].valid = 1'b1;
            next_st.found = 1'b1;
          end else begin
            next_st.err = 1'b1;
          end
        end
        mlt_pkg::OP_NEXT: begin
          next_st.found = nxt_hit;
          if (nxt_hit) begin
            next_st.res = st.tbl[nxt_idx];
            next_st.key_vlan = st.tbl[nxt_idx].vlan;
            next_st.key_addr = st.tbl[nxt_idx].addr;
          end
        end
        default: begin
          next_st.err = 1'b1;
        end
      endcase
    end

    // Register writes come last; a write here cannot meet a pending command
    if (apb_wr && addr_ok) begin
      case (paddr_i)
        mlt_pkg::REG_KEY_LO: begin
          next_st.key_addr[31:0] = pwdata_i;
        end
        mlt_pkg::REG_KEY_HI: begin
          next_st.key_addr[47:32] = pwdata_i[15:0];
        end
        mlt_pkg::REG_KEY_SEL: begin
          next_st.key_vlan = pwdata_i[mlt_pkg::VLAN_W-1:0];
          next_st.key_port = pwdata_i[mlt_pkg::KEY_PORT_LSB +: mlt_pkg::PORT_W];
        end
        mlt_pkg::REG_CMD: begin
          next_st.cmd_op = mlt_pkg::mlt_op_t'(pwdata_i[2:0]);
          next_st.cmd_dyn = pwdata_i[mlt_pkg::CMD_DYN_ONLY_BIT];
          next_st.cmd_pflt = pwdata_i[mlt_pkg::CMD_PORT_FLT_BIT];
          next_st.cmd_pend = pwdata_i[2:0] != 3'h0;
        end
        mlt_pkg::REG_AGE: begin
          if (pwdata_i[31:10] == 22'h000000 && pwdata_i[9:0] >= mlt_pkg::AGE_MIN
              && pwdata_i[9:0] <= mlt_pkg::AGE_MAX) begin
            next_st.age_time = pwdata_i[9:0];
            next_st.err = 1'b0;
          end else begin
            next_st.err = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Read mux
  always_comb begin
    prdata_o = 32'h0000_0000;
    if (psel_i && !pwrite_i && addr_ok) begin
      case (paddr_i)
        mlt_pkg::REG_KEY_LO: prdata_o = st.key_addr[31:0];
        mlt_pkg::REG_KEY_HI: prdata_o = {16'h0000, st.key_addr[47:32]};
        mlt_pkg::REG_KEY_SEL: prdata_o = {12'h000, st.key_port, 4'h0, st.key_vlan};
        mlt_pkg::REG_CMD: prdata_o = {26'h0000000, st.cmd_pflt, st.cmd_dyn,
                                      st.cmd_pend, st.cmd_op};
        mlt_pkg::REG_STATUS: prdata_o = {29'h00000000, !free_hit, st.err, st.found};
        mlt_pkg::REG_AGE: prdata_o = {22'h000000, st.age_time};
        mlt_pkg::REG_RES_LO: prdata_o = st.res.addr[31:0];
        mlt_pkg::REG_RES_HI: prdata_o = {16'h0000, st.res.addr[47:32]};
        mlt_pkg::REG_RES_INFO: prdata_o = {port_bit(st.res.port) & PORT_ALL, 2'h0,
                                           st.res.kind, st.res.vlan};
        default: prdata_o = 32'h0000_0000;
      endcase
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok;
  assign fwd_valid_o = st.fwd_valid;
  assign fwd_o = st.fwd;

endmodule // mlt_table

// >>> tb/mlt_table_sva.sv
// Purpose: Port-level checks of the layer-2 address table.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: Bound into every mlt_table instance.
`timescale 1ns/100ps
module mlt_table_sva #(
  parameter int NUM_PORTS = 10
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [mlt_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Frames
  input wire logic frm_valid_i,
  input wire mlt_pkg::mlt_frame_t frm_i,
  input wire logic [mlt_pkg::MASK_W-1:0] frm_flood_mask_i,
  input wire logic frm_ready_o,
  input wire logic fwd_valid_o,
  input wire mlt_pkg::mlt_fwd_t fwd_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic [15:0] ports_m;
  assign ports_m = 16'hFFFF >> (16 - NUM_PORTS);
  a_fwd_one_cycle: assert property (frm_valid_i && frm_ready_o |=> fwd_valid_o)
    else $error("Decision did not follow the frame");
  a_fwd_no_spur: assert property (!(frm_valid_i && frm_ready_o) |=> !fwd_valid_o)
    else $error("Decision without a taken frame");
  a_fwd_hold: assert property (!fwd_valid_o |-> $stable(fwd_o))
    else $error("Decision changed between frames");
  a_hit_single: assert property (fwd_valid_o && fwd_o.hit && !fwd_o.drop
    |-> $countones(fwd_o.mask) <= 1) else $error("Hit sent to several ports");
  a_drop_empty: assert property (fwd_valid_o && fwd_o.drop |-> fwd_o.mask == 16'h0000)
    else $error("Dropped frame still forwarded");
  a_no_ingress: assert property (fwd_valid_o |-> !fwd_o.mask[$past(frm_i.in_port)])
    else $error("Frame sent back to its ingress port");
  a_miss_flood: assert property (fwd_valid_o && !fwd_o.hit && !fwd_o.drop
    |-> fwd_o.mask == ($past(frm_flood_mask_i) & ports_m & ~(16'h0001 << $past(frm_i.in_port))))
    else $error("Flood mask wrong on miss");
  a_cmd_stall: assert property (psel_i && penable_i && pwrite_i && paddr_i == mlt_pkg::REG_CMD
    && pwdata_i[2:0] != 3'h0 |=> !frm_ready_o ##1 frm_ready_o)
    else $error("Command stall not one cycle");
  a_unmapped_err: assert property (psel_i && penable_i && paddr_i > 8'h20
    |-> pready_o && pslverr_o && (pwrite_i || prdata_o == 32'h0000_0000))
    else $error("Unmapped access not refused");
  c_drop: cover property (fwd_valid_o && fwd_o.drop);
  c_hit: cover property (fwd_valid_o && fwd_o.hit);
  c_stall: cover property (frm_valid_i && !frm_ready_o);
endmodule // mlt_table_sva
bind mlt_table mlt_table_sva #(.NUM_PORTS(NUM_PORTS)) u_mlt_table_sva (.clk_sys_i, .reset_n_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
  .frm_valid_i, .frm_i, .frm_flood_mask_i, .frm_ready_o, .fwd_valid_o, .fwd_o);

// >>> tb/mlt_pipe_model.sv
// Purpose: Forwarding pipeline model feeding frames and collecting decisions.
// Assumes: Bench queues frames with send(), frame and flood mask packed.
// Notes: Idle lines carry inverted data so a stale frame never looks valid.
`timescale 1ns/100ps
module mlt_pipe_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Table side
  input wire logic frm_ready_i,
  input wire logic fwd_valid_i,
  input wire mlt_pkg::mlt_fwd_t fwd_i,
  output logic frm_valid_o,
  output mlt_pkg::mlt_frame_t frm_o,
  output logic [15:0] flood_o
);
  logic [127:0] q[$];
  mlt_pkg::mlt_fwd_t last_fwd;
  int n_fwd;
  task automatic send(input logic [127:0] j);
    q.push_back(j);
  endtask
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frm_valid_o <= 1'b0;
      frm_o <= '0;
      flood_o <= 16'h0000;
      n_fwd <= 0;
      last_fwd <= '0;
    end else begin
      if (fwd_valid_i) begin
        last_fwd <= fwd_i;
        n_fwd <= n_fwd + 1;
      end
      // Refused frame is held until taken
      if (!frm_valid_o || frm_ready_i) begin
        if (q.size() > 0) begin
          {frm_o, flood_o} <= q.pop_front();
          frm_valid_o <= 1'b1;
        end else begin
          frm_valid_o <= 1'b0;
          frm_o <= ~frm_o;
          flood_o <= ~flood_o;
        end
      end
    end
  end
endmodule // mlt_pipe_model

// >>> tb/mlt_table_tb_top.sv
// Purpose: Self-checking bench for the layer-2 address table.
// Assumes: A second shortened to 20 cycles; seed 83.
// Notes: Frames go through the pipeline model, registers over APB.
`timescale 1ns/100ps
module mlt_table_tb_top;
  localparam int CPS = 20;
  logic clk_sys_i, reset_n_i, psel_i, penable_i, pwrite_i, err;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, ag;
  logic pready_o, pslverr_o, frm_valid_i, frm_ready_o, fwd_valid_o;
  mlt_pkg::mlt_frame_t frm_i;
  logic [15:0] frm_flood_mask_i;
  mlt_pkg::mlt_fwd_t fwd_o;
  int fails = 0, n_checks = 0, cyc = 0, n, np2;
  logic [47:0] la = 48'h0A00_0000_0001, lb = 48'h0B00_0000_0002;
  logic [47:0] sc = 48'h0C00_0000_0003, fd = 48'h0D00_0000_0004;
  logic [31:0] ages[5] = '{32'h9, 32'h277, 32'h40A, 32'hA, 32'h276};
  mlt_table #(.CYC_PER_SEC(CPS)) u_mlt_table (.clk_sys_i, .reset_n_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .frm_valid_i, .frm_i,
    .frm_flood_mask_i, .frm_ready_o, .fwd_valid_o, .fwd_o);
  mlt_pipe_model u_mlt_pipe_model (.clk_sys_i, .reset_n_i, .frm_ready_i(frm_ready_o),
    .fwd_valid_i(fwd_valid_o), .fwd_i(fwd_o), .frm_valid_o(frm_valid_i), .frm_o(frm_i),
    .flood_o(frm_flood_mask_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic cmd(input mlt_pkg::mlt_op_t op, input logic [47:0] k, input logic [11:0] v,
                     input logic [3:0] p, input logic [1:0] fl);
    apb(1'b1, mlt_pkg::REG_KEY_LO, k[31:0]);
    apb(1'b1, mlt_pkg::REG_KEY_HI, {16'h0000, k[47:32]});
    apb(1'b1, mlt_pkg::REG_KEY_SEL, {12'h000, p, 4'h0, v});
    apb(1'b1, mlt_pkg::REG_CMD, {26'h0, fl, 1'b0, op});
    apb(1'b0, mlt_pkg::REG_STATUS, 32'h0);
  endtask
  function automatic logic [17:0] miss(input logic [3:0] p);
    return {2'b00, 16'h03FF & ~(16'h0001 << p)};
  endfunction
  function automatic logic [17:0] hit(input logic [3:0] q, input logic [3:0] p);
    return {2'b01, (16'h0001 << q) & ~(16'h0001 << p)};
  endfunction
  // Flood mask has bits above the port count set on purpose
  task automatic fr(input logic [47:0] d, input logic [47:0] s, input logic [11:0] v,
                    input logic [3:0] p, input logic [17:0] e);
    int k;
    k = u_mlt_pipe_model.n_fwd;
    u_mlt_pipe_model.send({d, s, v, p, 16'hF3FF});
    repeat (20) if (u_mlt_pipe_model.n_fwd == k) @(posedge clk_sys_i);
    chk(32'(u_mlt_pipe_model.n_fwd - k), 32'h1);
    chk({14'h0, u_mlt_pipe_model.last_fwd}, {14'h0, e});
  endtask
  task automatic walk(input logic [1:0] fl, input logic [3:0] p, output int cnt);
    logic [59:0] prev, cur;
    prev = '0;
    cnt = 0;
    cmd(mlt_pkg::OP_NEXT, 48'h0, 12'h000, p, fl);
    repeat (20) if (rd[0]) begin
      apb(1'b0, mlt_pkg::REG_RES_LO, 32'h0);
      cur[31:0] = rd;
      apb(1'b0, mlt_pkg::REG_RES_HI, 32'h0);
      cur[47:32] = rd[15:0];
      apb(1'b0, mlt_pkg::REG_RES_INFO, 32'h0);
      cur[59:48] = rd[11:0];
      chk({31'h0, cur > prev}, 32'h1);
      chk({30'h0, fl[0] && rd[13:12] != 2'h0, fl[1] && !rd[16+p]}, 32'h0);
      prev = cur;
      cnt++;
      apb(1'b1, mlt_pkg::REG_CMD, {26'h0, fl, 1'b0, mlt_pkg::OP_NEXT});
      apb(1'b0, mlt_pkg::REG_STATUS, 32'h0);
    end
  endtask
  initial begin
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    reset_n_i = 1'b0;
    ag = 32'h12C;
    np2 = 0;
    void'($urandom(83));
    repeat (16) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    apb(1'b0, mlt_pkg::REG_AGE, 32'h0);
    chk(rd, 32'h12C);
    foreach (ages[i]) begin
      apb(1'b1, mlt_pkg::REG_AGE, ages[i]);
      apb(1'b0, mlt_pkg::REG_AGE, 32'h0);
      if (ages[i] >= 32'hA && ages[i] <= 32'h276) ag = ages[i];
      chk(rd, ag);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    fr(lb, la, 12'h005, 4'h2, miss(4'h2));
    fr(la, lb, 12'h005, 4'h3, hit(4'h2, 4'h3));
    repeat (5) begin
      logic [3:0] p;
      p = 4'($urandom_range(8, 0));
      if (p == 4'h2) np2++;
      fr({16'($urandom), $urandom}, {16'($urandom), $urandom}, 12'($urandom_range(4094, 1)),
         p, miss(p));
    end
    cmd(mlt_pkg::OP_ADD_STATIC, sc, 12'h005, 4'hA, 2'h0);
    chk({30'h0, rd[1:0]}, 32'h2);
    cmd(mlt_pkg::OP_ADD_STATIC, sc, 12'h005, 4'h9, 2'h0);
    chk({30'h0, rd[1:0]}, 32'h0);
    // Frames from la keep entering on port 2 so its learned port stays put
    fr(sc, la, 12'h005, 4'h2, hit(4'h9, 4'h2));
    fr(la, sc, 12'h005, 4'h4, hit(4'h2, 4'h4));
    fr(sc, la, 12'h005, 4'h2, hit(4'h9, 4'h2));
    cmd(mlt_pkg::OP_ADD_FILTER, fd, 12'h000, 4'h0, 2'h0);
    chk({31'h0, rd[1]}, 32'h1);
    cmd(mlt_pkg::OP_ADD_FILTER, fd, 12'hFFF, 4'h0, 2'h0);
    chk({31'h0, rd[1]}, 32'h1);
    cmd(mlt_pkg::OP_ADD_FILTER, fd, 12'h005, 4'h0, 2'h0);
    fr(fd, la, 12'h005, 4'h2, 18'h20000);
    walk(2'h0, 4'h0, n);
    chk(n, 32'h8);
    walk(2'h1, 4'h0, n);
    chk(n, 32'h7);
    walk(2'h3, 4'h2, n);
    chk(n, 32'(np2 + 1));
    cmd(mlt_pkg::OP_DELETE, sc, 12'h005, 4'h0, 2'h0);
    fr(sc, la, 12'h005, 4'h2, miss(4'h2));
    cmd(mlt_pkg::OP_DELETE, fd, 12'h005, 4'h0, 2'h0);
    fr(fd, la, 12'h005, 4'h2, miss(4'h2));
    cmd(mlt_pkg::OP_PROMOTE, la, 12'h005, 4'h0, 2'h0);
    chk({31'h0, rd[1]}, 32'h0);
    apb(1'b1, mlt_pkg::REG_AGE, 32'hA);
    // Two spare seconds cover tick phase
    repeat (12 * CPS) @(posedge clk_sys_i);
    fr(lb, la, 12'h005, 4'h3, miss(4'h3));
    fr(la, lb, 12'h005, 4'h3, hit(4'h2, 4'h3));
    cmd(mlt_pkg::OP_FLUSH, 48'h0, 12'h000, 4'h0, 2'h0);
    fr(lb, la, 12'h005, 4'h1, miss(4'h1));
    fr(la, lb, 12'h005, 4'h1, hit(4'h2, 4'h1));
    // lb now moves from port 1 to port 5
    fr(la, lb, 12'h005, 4'h5, hit(4'h2, 4'h5));
    fr(lb, sc, 12'h005, 4'h4, hit(4'h5, 4'h4));
    finish_test();
  end
endmodule // mlt_table_tb_top
